/* File: logic/pmfr_pkg.sv */
// register numbers, field limits, function codes and timing for the
// power monitor and delayed reset/restore register bank
// assumes a single 40 MHz core clock
package pmfr_pkg;
	localparam logic [15:0] TRIG_REG = 16'h1037;
	localparam logic [15:0] SEL_REG = 16'h1038;
	localparam logic [15:0] CHG_REG = 16'h17B7;
	localparam logic [15:0] BATT_REG = 16'h17C1;
	localparam logic [15:0] CURR_REG = 16'h17C2;
	localparam logic [15:0] SUPPLY_REG = 16'h17C3;
	localparam logic [15:0] TEMP_REG = 16'h17C4;
	localparam logic [7:0] SLAVE_ID_DEF = 8'hC8;
	localparam logic [15:0] TRIG_MAX = 16'h00FF;
	localparam logic [15:0] SEL_MAX = 16'h0001;
	localparam logic [15:0] CHG_MAX = 16'h0001;
	localparam logic [7:0] TRIG_RST = 8'h00;
	localparam logic SEL_RST = 1'b0;
	localparam logic CHG_RST = 1'b1;
	localparam logic CHG_SOLAR = 1'b0;
	localparam logic [7:0] FN_READ = 8'h03;
	localparam logic [7:0] FN_WRITE = 8'h06;
	localparam logic [7:0] FN_EXC = 8'h80;
	localparam logic [15:0] EXC_FUNC = 16'h0001;
	localparam logic [15:0] EXC_ADDR = 16'h0002;
	localparam logic [15:0] EXC_VALUE = 16'h0003;
	localparam int TICK_MS = 100;
	localparam longint CLK_HZ = 40_000_000;
	localparam int TICK_CYCLES = int'((longint'(TICK_MS) * CLK_HZ) / 1000);
endpackage

/* File: logic/pmfr_bank.sv */
// power monitor and delayed reset/restore register bank
// assumes requests arrive already decoded from the serial frame, one per
// cycle at most, on the core clock; monitor inputs come from core logic
// Summary of operation
// - charge source register: 0 solar panel, 1 (default) dc supply recharge
// - four read-only monitors: battery mV, charge mA, supply mV, temp C
// - trigger write 0-255 loads countdown in 100 ms ticks
// - at expiry restore factory defaults if select is 1, else board reset
// - restore select accepts 0 or 1, resets to 0
// - bank answers requests addressed to slave 200 by default
module pmfr_bank #(
	parameter logic [7:0] SlaveId = pmfr_pkg::SLAVE_ID_DEF,
	parameter int TickCycles = pmfr_pkg::TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic reqValid,
	input wire logic [7:0] reqSlave,
	input wire logic [7:0] reqFunc,
	input wire logic [15:0] reqAddr,
	input wire logic [15:0] reqData,
	input wire logic [15:0] battMv,
	input wire logic [15:0] chargeMa,
	input wire logic [15:0] supplyMv,
	input wire logic [15:0] boardTempC,
	output logic respValid,
	output logic [7:0] respFunc,
	output logic [15:0] respData,
	output logic chargeFromSupply,
	output logic countdownBusy,
	output logic boardResetPulse,
	output logic factoryRestorePulse
);
	import pmfr_pkg::*;

	localparam int TW = $clog2(TickCycles + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(TickCycles - 1);
	localparam logic [TW-1:0] TICK_ZERO = '0;
	localparam logic [7:0] TICKS_ONE = 8'h01;
	localparam logic [7:0] TICKS_ZERO = 8'h00;

	logic [7:0] trig_r;
	logic [TW-1:0] tick_r;
	logic sel_r;
	logic chg_r;
	logic respValid_r;
	logic [7:0] respFunc_r;
	logic [15:0] respData_r;
	logic rst_r;
	logic rest_r;
	logic mine;
	logic isRd;
	logic isWr;
	logic addrOk;
	logic valOk;
	logic [15:0] rdData;
	logic wrTrig;
	logic wrSel;
	logic wrChg;
	logic expire;
	logic supply_r;
	logic busy_r;
	logic [7:0] trig_nxt;
	logic [TW-1:0] tick_nxt;

	// address is one of the seven registers
	function automatic logic known(input logic [15:0] a);
		return a == TRIG_REG || a == SEL_REG || a == CHG_REG ||
			a == BATT_REG || a == CURR_REG || a == SUPPLY_REG ||
			a == TEMP_REG;
	endfunction

	assign mine = reqValid && reqSlave == SlaveId;
	assign isRd = reqFunc == FN_READ;
	assign isWr = reqFunc == FN_WRITE;

	// read data mux
	always_comb begin
		rdData = '0;
		unique case (reqAddr)
			TRIG_REG: rdData = {8'h00, trig_r};
			SEL_REG: rdData = {15'h0000, sel_r};
			CHG_REG: rdData = {15'h0000, chg_r};
			BATT_REG: rdData = battMv;
			CURR_REG: rdData = chargeMa;
			SUPPLY_REG: rdData = supplyMv;
			TEMP_REG: rdData = boardTempC;
			default: rdData = '0;
		endcase
	end

	// writable registers and their value range
	always_comb begin
		addrOk = known(reqAddr);
		valOk = 1'b0;
		if (isWr) begin
			unique case (reqAddr)
				TRIG_REG: valOk = reqData <= TRIG_MAX;
				SEL_REG: valOk = reqData <= SEL_MAX;
				CHG_REG: valOk = reqData <= CHG_MAX;
				default: addrOk = 1'b0;
			endcase
		end
	end

	assign wrTrig = mine && isWr && valOk && reqAddr == TRIG_REG;
	assign wrSel = mine && isWr && valOk && reqAddr == SEL_REG;
	assign wrChg = mine && isWr && valOk && reqAddr == CHG_REG;
	assign expire = trig_r == TICKS_ONE && tick_r == TICK_ZERO;

	// answer: echo on write, data on read, exception otherwise
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			respValid_r <= 1'b0;
			respFunc_r <= 8'h00;
			respData_r <= 16'h0000;
		end else begin
			respValid_r <= mine;
			if (mine) begin
				respFunc_r <= reqFunc;
			end
			if (!mine) begin
				respData_r <= respData_r;
			end else if (!isRd && !isWr) begin
				respFunc_r <= reqFunc | FN_EXC;
				respData_r <= EXC_FUNC;
			end else if (!addrOk) begin
				respFunc_r <= reqFunc | FN_EXC;
				respData_r <= EXC_ADDR;
			end else if (isWr && !valOk) begin
				respFunc_r <= reqFunc | FN_EXC;
				respData_r <= EXC_VALUE;
			end else if (isWr) begin
				respData_r <= reqData;
			end else begin
				respData_r <= rdData;
			end
		end
	end

	// charge source select and its registered output level
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			chg_r <= CHG_RST;
			supply_r <= CHG_RST != CHG_SOLAR;
		end else if (wrChg) begin
			chg_r <= reqData[0];
			supply_r <= reqData[0] != CHG_SOLAR;
		end
	end

	// restore select
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sel_r <= SEL_RST;
		end else if (wrSel) begin
			sel_r <= reqData[0];
		end
	end

	// next countdown state in ticks; a write reloads, zero cancels
	always_comb begin
		trig_nxt = trig_r;
		tick_nxt = tick_r;
		if (wrTrig) begin
			trig_nxt = reqData[7:0];
			tick_nxt = TICK_LAST;
		end else if (trig_r != TICKS_ZERO) begin
			if (tick_r == TICK_ZERO) begin
				tick_nxt = TICK_LAST;
				trig_nxt = trig_r - TICKS_ONE;
			end else begin
				tick_nxt = tick_r - TW'(1);
			end
		end
	end

	// countdown registers
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			trig_r <= TRIG_RST;
			tick_r <= TICK_LAST;
		end else begin
			trig_r <= trig_nxt;
			tick_r <= tick_nxt;
		end
	end

	// busy level, registered so it falls together with the expiry pulse
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= trig_nxt != TICKS_ZERO;
		end
	end

	// expiry action, chosen by select at the moment of expiry
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rst_r <= 1'b0;
			rest_r <= 1'b0;
		end else begin
			rest_r <= expire && !wrTrig && sel_r;
			rst_r <= expire && !wrTrig && !sel_r;
		end
	end

	assign respValid = respValid_r;
	assign respFunc = respFunc_r;
	assign respData = respData_r;
	assign chargeFromSupply = supply_r;
	assign countdownBusy = busy_r;
	assign boardResetPulse = rst_r;
	assign factoryRestorePulse = rest_r;
endmodule

/* File: tb/pmfr_bank_properties.sv */
// checker on the bank ports
// assumes binding to every pmfr_bank
module pmfr_bank_properties #(
	parameter logic [7:0] SlaveId = pmfr_pkg::SLAVE_ID_DEF
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic reqValid,
	input wire logic [7:0] reqSlave,
	input wire logic [7:0] reqFunc,
	input wire logic [15:0] reqAddr,
	input wire logic [15:0] reqData,
	input wire logic [15:0] battMv,
	input wire logic respValid,
	input wire logic [7:0] respFunc,
	input wire logic [15:0] respData,
	input wire logic chargeFromSupply,
	input wire logic countdownBusy,
	input wire logic boardResetPulse,
	input wire logic factoryRestorePulse
);
	timeunit 1ns;
	timeprecision 1ps;
	import pmfr_pkg::*;
	logic hit, wr, pulse;
	assign hit = reqValid && reqSlave == SlaveId;
	assign wr = hit && reqFunc == FN_WRITE;
	assign pulse = boardResetPulse || factoryRestorePulse;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	a_answer_slot: assert property (hit |=> respValid)
		else $error("no answer");
	a_read_live: assert property (hit && reqFunc == FN_READ &&
		reqAddr == BATT_REG |=> respData == $past(battMv)) else $error("mon");
	a_select_range: assert property (wr && reqAddr == SEL_REG &&
		reqData > SEL_MAX |=> respData == EXC_VALUE) else $error("sel");
	a_charge_level: assert property (wr && reqAddr == CHG_REG &&
		reqData <= CHG_MAX |=>
		chargeFromSupply == ($past(reqData) != 16'h0000))
		else $error("chg");
	a_trig_load: assert property (wr && reqAddr == TRIG_REG &&
		reqData inside {[1:255]} |=> countdownBusy) else $error("load");
	a_zero_idle: assert property (wr && reqAddr == TRIG_REG &&
		reqData == 0 |=> (!countdownBusy && !pulse) [*3]) else $error("zero");
	a_expiry_end: assert property (pulse |->
		$past(countdownBusy) && !countdownBusy) else $error("expiry");
	cover property (factoryRestorePulse);
	cover property (boardResetPulse);
	cover property (hit && reqFunc == FN_READ);
	cover property (respValid && (respFunc & FN_EXC) != 8'h00);
endmodule
bind pmfr_bank pmfr_bank_properties #(.SlaveId(SlaveId)) u_chk (
	.core_clk(core_clk),
	.nrst(nrst),
	.reqValid(reqValid),
	.reqSlave(reqSlave),
	.reqFunc(reqFunc),
	.reqAddr(reqAddr),
	.reqData(reqData),
	.battMv(battMv),
	.respValid(respValid),
	.respFunc(respFunc),
	.respData(respData),
	.chargeFromSupply(chargeFromSupply),
	.countdownBusy(countdownBusy),
	.boardResetPulse(boardResetPulse),
	.factoryRestorePulse(factoryRestorePulse)
);

/* File: tb/pmfr_master.sv */
// master model issuing decoded requests
// assumes the answer one cycle after each request
module pmfr_master (
	input wire logic core_clk,
	input wire logic respValid,
	input wire logic [7:0] respFunc,
	input wire logic [15:0] respData,
	output logic reqValid,
	output logic [7:0] reqSlave,
	output logic [7:0] reqFunc,
	output logic [15:0] reqAddr,
	output logic [15:0] reqData
);
	timeunit 1ns;
	timeprecision 1ps;
	import pmfr_pkg::*;
	initial {reqValid, reqSlave, reqFunc, reqAddr, reqData} = '0;
	task automatic xfer(logic [7:0] s, f, logic [15:0] a, d,
		output logic v, output logic [7:0] rf, output logic [15:0] rd);
		@(negedge core_clk);
		{reqValid, reqSlave, reqFunc, reqAddr, reqData} = {1'b1, s, f, a, d};
		@(negedge core_clk);
		reqValid = 0;
		{reqAddr, reqData} = ~{a, d};
		{v, rf, rd} = {respValid, respFunc, respData};
	endtask
	task automatic restore(logic [15:0] sel, trig);
		logic v;
		logic [7:0] rf;
		logic [15:0] rd;
		xfer(SLAVE_ID_DEF, FN_WRITE, SEL_REG, sel, v, rf, rd);
		xfer(SLAVE_ID_DEF, FN_WRITE, TRIG_REG, trig, v, rf, rd);
	endtask
endmodule

/* File: tb/tb_pmfr_bank.sv */
// bench for the bank through the master model
// assumes TickCycles shortened to 4
module tb_pmfr_bank;
	timeunit 1ns;
	timeprecision 1ps;
	import pmfr_pkg::*;
	localparam int T = 4;
	logic core_clk = 0, nrst = 0, respValid, chargeFromSupply, v;
	logic countdownBusy, boardResetPulse, factoryRestorePulse, reqValid;
	logic [7:0] reqSlave, reqFunc, respFunc, rf;
	logic [15:0] reqAddr, reqData, respData, rd;
	logic [15:0] mon [4] = '{16'h3039, 16'h01F4, 16'h5DC0, 16'h0019};
	int n_mismatch = 0, n_compared = 0, n;
	pmfr_bank #(.TickCycles(T)) u_dut (
		.core_clk(core_clk),
		.nrst(nrst),
		.reqValid(reqValid),
		.reqSlave(reqSlave),
		.reqFunc(reqFunc),
		.reqAddr(reqAddr),
		.reqData(reqData),
		.battMv(mon[0]),
		.chargeMa(mon[1]),
		.supplyMv(mon[2]),
		.boardTempC(mon[3]),
		.respValid(respValid),
		.respFunc(respFunc),
		.respData(respData),
		.chargeFromSupply(chargeFromSupply),
		.countdownBusy(countdownBusy),
		.boardResetPulse(boardResetPulse),
		.factoryRestorePulse(factoryRestorePulse)
	);
	pmfr_master u_mst (
		.core_clk(core_clk),
		.respValid(respValid),
		.respFunc(respFunc),
		.respData(respData),
		.reqValid(reqValid),
		.reqSlave(reqSlave),
		.reqFunc(reqFunc),
		.reqAddr(reqAddr),
		.reqData(reqData)
	);
	initial forever #12.5 core_clk = ~core_clk;
	initial begin
		#100us;
		n_mismatch++;
		finish_test();
	end
	task automatic finish_test();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [15:0] e, g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: exp %h seen %h", nm, e, g);
		end
	endtask
	task automatic tx(logic [7:0] f, logic [15:0] a, d, logic [7:0] ef,
		logic [15:0] ed);
		u_mst.xfer(SLAVE_ID_DEF, f, a, d, v, rf, rd);
		chk("answer", 1, v);
		chk("func", ef, rf);
		chk("data", ed, rd);
	endtask
	task automatic expire(logic [15:0] sel, trig, logic rst, fac);
		u_mst.restore(sel, trig);
		for (n = 1; n < 999 && !(boardResetPulse | factoryRestorePulse); n++)
			@(negedge core_clk);
		// the pulse lands one edge after the last tick has run out
		chk("ticks", 16'(trig * T + 1), 16'(n));
		chk("reset", rst, boardResetPulse);
		chk("restore", fac, factoryRestorePulse);
	endtask
	initial begin
		repeat (10) @(negedge core_clk);
		nrst = 1;
		chk("supply", 1, chargeFromSupply);
		tx(FN_READ, CHG_REG, 0, FN_READ, 1);
		tx(FN_READ, SEL_REG, 0, FN_READ, 0);
		tx(FN_READ, TRIG_REG, 0, FN_READ, 0);
		for (int i = 0; i < 4; i++)
			tx(FN_READ, BATT_REG + 16'(i), 0, FN_READ, mon[i]);
		tx(FN_WRITE, CHG_REG, 0, FN_WRITE, 0);
		chk("supply", 0, chargeFromSupply);
		tx(FN_WRITE, CHG_REG, 2, FN_WRITE | FN_EXC, EXC_VALUE);
		tx(FN_WRITE, SEL_REG, 2, FN_WRITE | FN_EXC, EXC_VALUE);
		tx(FN_WRITE, BATT_REG, 1, FN_WRITE | FN_EXC, EXC_ADDR);
		tx(8'h10, CHG_REG, 0, 8'h10 | FN_EXC, EXC_FUNC);
		tx(FN_READ, 16'h0000, 0, FN_READ | FN_EXC, EXC_ADDR);
		u_mst.xfer(8'hC9, FN_READ, CHG_REG, 0, v, rf, rd);
		chk("answer", 0, v);
		expire(1, 10, 0, 1);
		expire(0, 1, 1, 0);
		tx(FN_WRITE, TRIG_REG, 5, FN_WRITE, 5);
		chk("busy", 1, countdownBusy);
		tx(FN_READ, TRIG_REG, 0, FN_READ, 5);
		tx(FN_WRITE, TRIG_REG, 0, FN_WRITE, 0);
		repeat (30) begin
			@(negedge core_clk);
			chk("pulse", 0, boardResetPulse | factoryRestorePulse);
		end
		chk("busy", 0, countdownBusy);
		finish_test();
	end
endmodule
